// ---- rtl/dual_timer_pkg.sv ----
/*
 * shared constants and types for the dual timer/counter block:
 * register byte addresses, control bit positions, mode codes, carriers.
 * assumes a 32-bit apb bus with 8-bit byte addresses.
 */
package dual_timer_pkg;

   // =====================================================================
   // register map (byte addresses, one aligned word each)
   localparam int          APB_AW      = 8;
   localparam logic [7:0]  ADDR_CTRL   = 8'h88;  // timer_and_ext_irq_control
   localparam logic [7:0]  ADDR_MODE   = 8'h8c;  // timer_mode_reg
   localparam logic [7:0]  ADDR_AUX    = 8'h90;  // auxiliary_control
   localparam logic [7:0]  ADDR_LO0    = 8'h94;
   localparam logic [7:0]  ADDR_HI0    = 8'h98;
   localparam logic [7:0]  ADDR_LO1    = 8'h9c;
   localparam logic [7:0]  ADDR_HI1    = 8'ha0;
   localparam logic [7:0]  RESET_BYTE  = 8'h00;

   // =====================================================================
   // control register bits; timer n / irq n sits at base + 2*n
   localparam int          CTRL_IT0    = 0;
   localparam int          CTRL_IE0    = 1;
   localparam int          CTRL_TR0    = 4;
   localparam int          CTRL_TF0    = 5;

   // mode register: nibble per timer, timer n at 4*n
   localparam int          MODE_M0     = 0;
   localparam int          MODE_M1     = 1;
   localparam int          MODE_CSEL   = 2;
   localparam int          MODE_GATE   = 3;
   localparam int          NIB         = 4;

   // auxiliary register: nibble per timer, timer n at 4*n
   localparam int          AUX_M2      = 0;
   localparam int          AUX_TOGGLE  = 1;

   // =====================================================================
   // mode codes
   typedef enum logic [2:0] {
      MODE_13BIT  = 3'b000,
      MODE_16BIT  = 3'b001,
      MODE_RELOAD = 3'b010,
      MODE_SPLIT  = 3'b011,
      MODE_RSV4   = 3'b100,
      MODE_RSV5   = 3'b101,
      MODE_PWM    = 3'b110,
      MODE_RSV7   = 3'b111
   } mode_t;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } count_t;

   typedef struct packed {
      logic       ovf;
      count_t     c;
   } step_t;

endpackage

// ---- rtl/dual_timer_counter.sv ----
/*
 * two timer/counters with 13-bit, 16-bit, auto-reload, split and pwm
 * modes, external interrupt flags and overflow toggle outputs.
 * assumes: apb master on i_clk, core clock is i_clk, pins are asynchronous.
 */
// Added by the designer: the APB interface to the registers.
// Notes on behaviour
// - 13-bit mode: high byte plus low five bits of the low byte.
// - wrap from all ones to zero sets the overflow flag.
// - count only while run bit set and gate off or irq pin high.
// - setting run bit resumes counting without clearing count bytes.
// - 16-bit mode: full cascaded high and low bytes, no prescaler.
// - reload mode: low byte overflows, flag set, high byte copied in.
// - timer one in split mode stops as if run bit cleared.
// - split: low byte uses timer zero controls; high byte counts cycles.
// - timer zero split: timer one runs unless in its own split mode.
// - pwm period 256 clocks, low phase equals high-byte value.
// - pwm pin forced high for 00, forced low for ff.
// - pwm: hardware sets and clears flag; software may clear.
// - run bits at control bits 4 and 6.
// - overflow flags bits 5,7 cleared by vector ack or write.
// - type bits 0,2 select falling edge or low level.
// - irq flags bits 1,3 set on detect, cleared by ack or write.
// - toggle enable inverts the timer pin on every overflow outside pwm mode; in pwm mode the pin follows the wave.
// - toggle pin reads one until the first overflow.
// - gate bits: mode bit 7 timer one, bit 3 timer zero.
// - three-bit mode code per timer; reserved codes hold the count.
// - counter select picks core clock or external count pin.
`timescale 1ns/10ps
module dual_timer_counter (
   input  wire logic                          i_clk,
   input  wire logic                          i_reset_n,
   input  wire logic                          i_psel,
   input  wire logic                          i_penable,
   input  wire logic                          i_pwrite,
   input  wire logic [dual_timer_pkg::APB_AW-1:0] i_paddr,
   input  wire logic [31:0]                   i_pwdata,
   output logic      [31:0]                   o_prdata,
   output logic                               o_pready,
   output logic                               o_pslverr,
   input  wire logic [1:0]                    i_count_pin,
   input  wire logic [1:0]                    i_ext_irq_pin,
   input  wire logic [1:0]                    i_tmr_vector_ack,
   input  wire logic [1:0]                    i_ext_vector_ack,
   output logic      [1:0]                    o_tmr_pin_out,
   output logic      [1:0]                    o_tmr_pin_oe,
   output logic      [1:0]                    o_ovf_flag,
   output logic      [1:0]                    o_ext_flag
);
   import dual_timer_pkg::*;

   // =====================================================================
   // state
   logic [7:0]   ctrl_r;
   logic [7:0]   mode_r;
   logic [7:0]   aux_r;
   count_t       cnt_r      [2];
   logic [1:0]   pin_r;
   logic [1:0]   oe_r;
   logic         pready_r;
   logic         pslverr_r;
   logic [31:0]  prdata_r;
   logic [1:0]   cnt_s1, cnt_s2, cnt_s3;
   logic [1:0]   irq_s1, irq_s2, irq_s3;

   // =====================================================================
   // combinational terms
   logic         commit;
   logic         wr_ctrl, wr_mode, wr_aux;
   logic [1:0]   wr_lo, wr_hi;
   logic         hit;
   logic [7:0]   rd_byte;
   logic [1:0]   pin_fall, irq_fall, gate_ok, tick, run;
   mode_t        mode       [2];
   step_t        st         [2];
   count_t       cnt_nxt    [2];
   logic [1:0]   wave_nxt;
   logic [1:0]   ovf_ev;
   logic         split0, th0_run, th0_ovf;
   logic [1:0]   set_e, set_t, pwm_n;

   // mode code of timer n from mode and auxiliary registers
   function automatic mode_t mode_of(input int n);
      mode_of = mode_t'({aux_r[NIB*n+AUX_M2], mode_r[NIB*n+MODE_M1], mode_r[NIB*n+MODE_M0]});
   endfunction

   // one count step of a timer; reserved codes never advance
   function automatic step_t step_count(input count_t c, input mode_t m);
      step_t s;
      s = '{ovf: 1'b0, c: c};
      case (m)
         MODE_13BIT: begin
            s.c.lo[4:0] = c.lo[4:0] + 5'h01;
            if (c.lo[4:0] == 5'h1f) begin
               s.c.hi = c.hi + 8'h01;
               s.ovf  = (c.hi == 8'hff);
            end
         end
         MODE_16BIT: begin
            s.c   = count_t'(16'(c + 16'h0001));
            s.ovf = (c == 16'hffff);
         end
         MODE_RELOAD: begin
            s.ovf  = (c.lo == 8'hff);
            s.c.lo = s.ovf ? c.hi : c.lo + 8'h01;
         end
         MODE_SPLIT, MODE_PWM: begin
            s.c.lo = c.lo + 8'h01;
            s.ovf  = (c.lo == 8'hff);
         end
         default: begin
            s.ovf = 1'b0;
         end
      endcase
      return s;
   endfunction

   // =====================================================================
   // pin synchronisers; third stage only feeds the edge detectors
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_s1 <= 2'h3;
         cnt_s2 <= 2'h3;
         cnt_s3 <= 2'h3;
         irq_s1 <= 2'h3;
         irq_s2 <= 2'h3;
         irq_s3 <= 2'h3;
      end else begin
         cnt_s1 <= i_count_pin;
         cnt_s2 <= cnt_s1;
         cnt_s3 <= cnt_s2;
         irq_s1 <= i_ext_irq_pin;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
      end
   end

   assign pin_fall = cnt_s3 & ~cnt_s2;
   assign irq_fall = irq_s3 & ~irq_s2;

   // =====================================================================
   // apb slave: one wait state, answer registered
   assign commit  = i_psel & i_penable & pready_r;
   assign wr_ctrl = commit & i_pwrite & (i_paddr == ADDR_CTRL);
   assign wr_mode = commit & i_pwrite & (i_paddr == ADDR_MODE);
   assign wr_aux  = commit & i_pwrite & (i_paddr == ADDR_AUX);
   assign wr_lo   = {commit & i_pwrite & (i_paddr == ADDR_LO1), commit & i_pwrite & (i_paddr == ADDR_LO0)};
   assign wr_hi   = {commit & i_pwrite & (i_paddr == ADDR_HI1), commit & i_pwrite & (i_paddr == ADDR_HI0)};

   // read mux and address decode
   always_comb begin
      hit     = 1'b1;
      rd_byte = RESET_BYTE;
      if (i_paddr == ADDR_CTRL) begin
         rd_byte = ctrl_r;
      end else if (i_paddr == ADDR_MODE) begin
         rd_byte = mode_r;
      end else if (i_paddr == ADDR_AUX) begin
         rd_byte = aux_r;
      end else if (i_paddr == ADDR_LO0) begin
         rd_byte = cnt_r[0].lo;
      end else if (i_paddr == ADDR_HI0) begin
         rd_byte = cnt_r[0].hi;
      end else if (i_paddr == ADDR_LO1) begin
         rd_byte = cnt_r[1].lo;
      end else if (i_paddr == ADDR_HI1) begin
         rd_byte = cnt_r[1].hi;
      end else begin
         hit = 1'b0;
      end
   end

   // handshake: pready rises in the second access cycle
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= i_psel & i_penable & ~pready_r;
         if (i_psel & i_penable & ~pready_r) begin
            pslverr_r <= ~hit;
            prdata_r  <= (i_pwrite | ~hit) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // =====================================================================
   // count enables
   always_comb begin
      split0 = (mode_of(0) == MODE_SPLIT);
      for (int n = 0; n < 2; n++) begin
         mode[n]    = mode_of(n);
         gate_ok[n] = ~mode_r[NIB*n+MODE_GATE] | irq_s2[n];
         tick[n]    = mode_r[NIB*n+MODE_CSEL] ? pin_fall[n] : 1'b1;
      end
      run[0]  = ctrl_r[CTRL_TR0] & gate_ok[0] & tick[0];
      // timer one: run bit lent to split high byte, stopped in own split
      run[1]  = (split0 | ctrl_r[CTRL_TR0+2]) & gate_ok[1] & tick[1]
                & (mode[1] != MODE_SPLIT);
      th0_run = split0 & ctrl_r[CTRL_TR0+2];
      th0_ovf = th0_run & (cnt_r[0].hi == 8'hff);
   end

   // next counts, pwm wave and overflow events
   always_comb begin
      for (int n = 0; n < 2; n++) begin
         st[n]      = step_count(cnt_r[n], mode[n]);
         cnt_nxt[n] = run[n] ? st[n].c : cnt_r[n];
         ovf_ev[n]  = run[n] & st[n].ovf;
      end
      if (th0_run) begin
         cnt_nxt[0].hi = cnt_r[0].hi + 8'h01;
      end
      for (int n = 0; n < 2; n++) begin
         if (wr_lo[n]) begin
            cnt_nxt[n].lo = i_pwdata[7:0];
         end
         if (wr_hi[n]) begin
            cnt_nxt[n].hi = i_pwdata[7:0];
         end
         // low while count below high byte; ff forces low
         wave_nxt[n] = (cnt_nxt[n].hi != 8'hff) & (cnt_nxt[n].lo >= cnt_nxt[n].hi);
      end
      // flag set terms; kept out of the clocked block so it holds only registers
      for (int n = 0; n < 2; n++) begin
         set_e[n] = ctrl_r[CTRL_IT0+2*n] ? irq_fall[n] : ~irq_s2[n];
         pwm_n[n] = (mode[n] == MODE_PWM) & ~((n == 1) & split0);
      end
      set_t[0] = ovf_ev[0] & ~pwm_n[0];
      set_t[1] = split0 ? th0_ovf : (ovf_ev[1] & ~pwm_n[1]);
   end

   // =====================================================================
   // count registers; run bit changes never touch them
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_r[0] <= '0;
         cnt_r[1] <= '0;
      end else begin
         cnt_r[0] <= cnt_nxt[0];
         cnt_r[1] <= cnt_nxt[1];
      end
   end

   // mode and auxiliary registers
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         mode_r <= RESET_BYTE;
         aux_r  <= RESET_BYTE;
      end else begin
         if (wr_mode) begin
            mode_r <= i_pwdata[7:0];
         end
         if (wr_aux) begin
            aux_r <= i_pwdata[7:0];
         end
      end
   end

   // =====================================================================
   // control register: hardware set wins over any clear
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         ctrl_r <= RESET_BYTE;
      end else begin
         for (int n = 0; n < 2; n++) begin
            if (wr_ctrl) begin
               ctrl_r[CTRL_IT0+2*n] <= i_pwdata[CTRL_IT0+2*n];
               ctrl_r[CTRL_TR0+2*n] <= i_pwdata[CTRL_TR0+2*n];
            end
            ctrl_r[CTRL_IE0+2*n] <= set_e[n] | ((wr_ctrl ? i_pwdata[CTRL_IE0+2*n] : ctrl_r[CTRL_IE0+2*n])
                                                & ~i_ext_vector_ack[n]);
            if (pwm_n[n] & run[n]) begin
               ctrl_r[CTRL_TF0+2*n] <= wave_nxt[n];
            end else if (pwm_n[n]) begin
               ctrl_r[CTRL_TF0+2*n] <= wr_ctrl ? i_pwdata[CTRL_TF0+2*n] : ctrl_r[CTRL_TF0+2*n];
            end else begin
               ctrl_r[CTRL_TF0+2*n] <= set_t[n] | ((wr_ctrl ? i_pwdata[CTRL_TF0+2*n] : ctrl_r[CTRL_TF0+2*n])
                                                   & ~i_tmr_vector_ack[n]);
            end
         end
      end
   end

   // =====================================================================
   // timer pins: pwm wave or overflow toggle, idle high
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         pin_r <= 2'h3;
         oe_r  <= 2'h0;
      end else begin
         for (int n = 0; n < 2; n++) begin
            oe_r[n] <= aux_r[NIB*n+AUX_TOGGLE] | (mode[n] == MODE_PWM);
            if (mode[n] == MODE_PWM) begin
               pin_r[n] <= wave_nxt[n];
            end else if (!aux_r[NIB*n+AUX_TOGGLE]) begin
               pin_r[n] <= 1'b1;
            end else if (ovf_ev[n]) begin
               pin_r[n] <= ~pin_r[n];
            end
         end
      end
   end

   // outputs straight from flip-flops
   assign o_prdata      = prdata_r;
   assign o_pready      = pready_r;
   assign o_pslverr     = pslverr_r;
   assign o_tmr_pin_out = pin_r;
   assign o_tmr_pin_oe  = oe_r;
   assign o_ovf_flag    = {ctrl_r[CTRL_TF0+2], ctrl_r[CTRL_TF0]};
   assign o_ext_flag    = {ctrl_r[CTRL_IE0+2], ctrl_r[CTRL_IE0]};

   // =====================================================================
   // checks
   property p_13bit_step;
      @(posedge i_clk) disable iff (!i_reset_n)
      (mode[0] == MODE_13BIT && run[0] && cnt_r[0].lo[4:0] != 5'h1f && !wr_lo[0] && !wr_hi[0])
      |=> (cnt_r[0].lo[4:0] == $past(cnt_r[0].lo[4:0]) + 5'h01) && $stable(cnt_r[0].hi);
   endproperty
   a_13bit_step: assert property (p_13bit_step) else $error("13-bit step wrong");

   property p_16bit_ovf;
      @(posedge i_clk) disable iff (!i_reset_n)
      (mode[0] == MODE_16BIT && run[0] && cnt_r[0] == 16'hffff && !wr_ctrl && !wr_lo[0] && !wr_hi[0])
      |=> ctrl_r[CTRL_TF0] && cnt_r[0] == 16'h0000;
   endproperty
   a_16bit_ovf: assert property (p_16bit_ovf) else $error("16-bit wrap did not set flag");

   property p_stopped_holds;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!ctrl_r[CTRL_TR0] && !split0 && !wr_lo[0] && !wr_hi[0]) |=> $stable(cnt_r[0]);
   endproperty
   a_stopped_holds: assert property (p_stopped_holds) else $error("timer zero moved while stopped");

   property p_reload;
      @(posedge i_clk) disable iff (!i_reset_n)
      (mode[0] == MODE_RELOAD && run[0] && cnt_r[0].lo == 8'hff && !wr_lo[0] && !wr_hi[0])
      |=> cnt_r[0].lo == $past(cnt_r[0].hi) && $stable(cnt_r[0].hi);
   endproperty
   a_reload: assert property (p_reload) else $error("reload did not copy high byte");

   property p_t1_split_stop;
      @(posedge i_clk) disable iff (!i_reset_n)
      (mode[1] == MODE_SPLIT && !wr_lo[1] && !wr_hi[1]) |=> $stable(cnt_r[1]);
   endproperty
   a_t1_split_stop: assert property (p_t1_split_stop) else $error("timer one counted in split");

   property p_split_high;
      @(posedge i_clk) disable iff (!i_reset_n)
      (split0 && ctrl_r[CTRL_TR0+2] && !wr_hi[0]) ##1 (split0 && ctrl_r[CTRL_TR0+2] && !wr_hi[0])
      |=> cnt_r[0].hi == $past(cnt_r[0].hi, 2) + 8'h02;
   endproperty
   a_split_high: assert property (p_split_high) else $error("split high byte not counting cycles");

   property p_pwm_zero;
      @(posedge i_clk) disable iff (!i_reset_n)
      (mode[0] == MODE_PWM && cnt_r[0].hi == 8'h00 && !wr_hi[0] && !wr_aux && !wr_mode)
      |=> o_tmr_pin_out[0] && o_tmr_pin_oe[0];
   endproperty
   a_pwm_zero: assert property (p_pwm_zero) else $error("pwm pin not high for zero");

   property p_ext_edge;
      @(posedge i_clk) disable iff (!i_reset_n)
      (ctrl_r[CTRL_IT0] && irq_fall[0]) |=> o_ext_flag[0];
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("edge did not set irq flag");

   property p_toggle_start;
      @(posedge i_clk) disable iff (!i_reset_n)
      ($rose(aux_r[AUX_TOGGLE]) && mode[0] != MODE_PWM) |-> o_tmr_pin_out[0];
   endproperty
   a_toggle_start: assert property (p_toggle_start) else $error("toggle pin not high at enable");

endmodule

// ---- verification/pin_side_model.sv ----
/* pin-side model: the count pins and external irq pins seen by the timers.
   assumes pull-ups on both pin pairs and a count pin shared with the timer output. */
`timescale 1ns/10ps
module pin_side_model (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_pin_out,
   input  wire logic [1:0] i_pin_oe,
   output logic      [1:0] o_count_pin,
   output logic      [1:0] o_ext_irq_pin
);
   // ====================================================
   // pin levels, idle high as the pull-ups leave them
   logic [1:0] drv = 2'b11;
   logic [1:0] irq = 2'b11;
   // the design owns the shared pin while its enable is up
   assign o_count_pin   = (i_pin_oe & i_pin_out) | (~i_pin_oe & drv);
   assign o_ext_irq_pin = irq;
   // ====================================================
   // falling pulses, three cycles low and three high so none is lost
   task automatic pulse(input int n, input int k);
      repeat (k) begin
         @(posedge i_clk);
         drv[n] <= 1'b0;
         repeat (3) @(posedge i_clk);
         drv[n] <= 1'b1;
         repeat (2) @(posedge i_clk);
      end
   endtask
   // irq level change, made just after an edge
   task automatic set_irq(input int n, input logic v);
      @(posedge i_clk);
      irq[n] <= v;
   endtask
endmodule

// ---- verification/test_dual_timer_counter.sv ----
/* self-checking bench for the dual timer/counter: register rows, run rows,
   then gate, irq, pin counting and pwm. assumes the pin model beside it. */
`timescale 1ns/10ps
module test_dual_timer_counter;
   import dual_timer_pkg::*;
   logic i_clk, i_reset_n, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] cpin, ipin, tack, eack, pin_out, pin_oe, ovf, ext;
   int err_total, n_compared, cycles, k, lows, bad;
   typedef struct packed { logic [7:0] a, wd, ex; logic err; } reg_row_t;
   typedef struct packed { int t, f; logic [7:0] mode, aux, hi, lo, run; logic ov; logic [7:0] ca, cv; } run_row_t;
   // the auxiliary row raises both toggle enables while no timer runs
   reg_row_t rg[7] = '{'{ADDR_MODE, 8'h5a, 8'h5a, 0}, '{ADDR_AUX, 8'h22, 8'h22, 0},
      '{ADDR_LO0, 8'ha5, 8'ha5, 0}, '{ADDR_HI0, 8'h3c, 8'h3c, 0}, '{ADDR_LO1, 8'hc3, 8'hc3, 0},
      '{ADDR_HI1, 8'h69, 8'h69, 0}, '{8'hfc, 8'h77, 8'h00, 1}};
   // 13-bit, 16-bit, reload, toggle, split high byte, timer one split, reserved
   run_row_t rr[7] = '{'{0, 0, 8'h00, 8'h00, 8'hff, 8'h1e, 8'h10, 1, ADDR_HI0, 8'h00},
      '{0, 0, 8'h01, 8'h00, 8'hff, 8'hf0, 8'h10, 1, ADDR_HI0, 8'h00},
      '{0, 0, 8'h02, 8'h00, 8'h80, 8'hf0, 8'h10, 1, ADDR_HI0, 8'h80},
      '{1, 1, 8'h10, 8'h20, 8'hff, 8'hf0, 8'h40, 1, ADDR_HI1, 8'h00},
      '{0, 1, 8'h03, 8'h00, 8'hf8, 8'h00, 8'h40, 1, ADDR_LO0, 8'h00},
      '{1, 1, 8'h30, 8'h00, 8'hff, 8'hff, 8'h40, 0, ADDR_HI1, 8'hff},
      '{0, 0, 8'h00, 8'h01, 8'hff, 8'hff, 8'h10, 0, ADDR_HI0, 8'hff}};
   logic [7:0] pw[3] = '{8'h00, 8'h40, 8'hff};

   dual_timer_counter dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_count_pin(cpin), .i_ext_irq_pin(ipin), .i_tmr_vector_ack(tack),
      .i_ext_vector_ack(eack), .o_tmr_pin_out(pin_out), .o_tmr_pin_oe(pin_oe), .o_ovf_flag(ovf),
      .o_ext_flag(ext));
   pin_side_model pins (.i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_count_pin(cpin),
      .o_ext_irq_pin(ipin));

   // ====================================================
   // clock and hang guard
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         final_report();
      end
   end
   // ====================================================
   // checks and reports
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkn(input string nm, input int e, input int g);
      n_compared++;
      if (g != e) begin
         err_total++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic done(input string s);
      $display("test %s ended", s);
   endtask
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ====================================================
   // apb master: setup, access, hold until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge i_clk);
      penable <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk("read data", {24'h000000, e}, rd);
   endtask
   // one run row: load, start, wait for overflow, ack, stop, read back
   task automatic run_case(input run_row_t r);
      wr(ADDR_MODE, r.mode);
      wr(ADDR_AUX, r.aux);
      wr(r.t ? ADDR_LO1 : ADDR_LO0, r.lo);
      wr(r.t ? ADDR_HI1 : ADDR_HI0, r.hi);
      if (r.aux[1 + NIB * r.t]) chk("toggle pin idle", 1, pin_out[r.t]);
      if (r.aux[1 + NIB * r.t]) chk("toggle pin enable", 1, pin_oe[r.t]);
      wr(ADDR_CTRL, r.run);
      k = 0;
      while (ovf[r.f] !== 1'b1 && k < 300) begin
         @(posedge i_clk);
         k++;
      end
      chk("overflow flag", r.ov, ovf[r.f]);
      if (r.aux[1 + NIB * r.t]) chk("toggle pin", 0, pin_out[r.t]);
      @(posedge i_clk);
      tack[r.f] <= 1'b1;
      @(posedge i_clk);
      tack <= 2'b00;
      repeat (2) @(posedge i_clk);
      chk("flag after ack", 0, ovf[r.f]);
      wr(ADDR_CTRL, 8'h00);
      rchk(r.ca, r.cv);
      wr(ADDR_AUX, 8'h00);
   endtask
   // ====================================================
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, tack, eack} = '0;
      {err_total, n_compared, cycles} = '0;
      i_reset_n = 1'b0;
      repeat (8) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rchk(ADDR_CTRL, RESET_BYTE);
      chk("pins after reset", {2'b11, 2'b00, 4'h0}, {pin_out, pin_oe, ovf, ext});
      done("reset");
      foreach (rg[i]) begin
         wr(rg[i].a, rg[i].wd);
         chk("write error", rg[i].err, er);
         rchk(rg[i].a, rg[i].ex);
         chk("read error", rg[i].err, er);
      end
      done("registers");
      // rows 0..6 top low bits unread
      foreach (rr[i]) run_case(rr[i]);
      done("run rows");
      // gated timer held while irq pin low, free once high
      wr(ADDR_MODE, 8'h09);
      wr(ADDR_LO0, 8'hff);
      wr(ADDR_HI0, 8'hff);
      pins.set_irq(0, 1'b0);
      wr(ADDR_CTRL, 8'h10);
      repeat (20) @(posedge i_clk);
      chk("gate closed", 0, ovf[0]);
      pins.set_irq(0, 1'b1);
      repeat (8) @(posedge i_clk);
      chk("gate open", 1, ovf[0]);
      wr(ADDR_CTRL, 8'h00);
      done("gate");
      // edge type: one flag per fall; level type: flag returns while low
      wr(ADDR_CTRL, 8'h01);
      pins.set_irq(0, 1'b0);
      repeat (6) @(posedge i_clk);
      chk("edge flag", 1, ext[0]);
      eack[0] <= 1'b1;
      @(posedge i_clk);
      eack <= 2'b00;
      repeat (4) @(posedge i_clk);
      chk("edge flag acked", 0, ext[0]);
      wr(ADDR_CTRL, 8'h00);
      repeat (4) @(posedge i_clk);
      chk("level flag", 1, ext[0]);
      pins.set_irq(0, 1'b1);
      wr(ADDR_CTRL, 8'h00);
      done("irq");
      // external count pin: three falls wrap fffd
      wr(ADDR_MODE, 8'h05);
      wr(ADDR_LO0, 8'hfd);
      wr(ADDR_HI0, 8'hff);
      wr(ADDR_CTRL, 8'h10);
      pins.pulse(0, 2);
      repeat (6) @(posedge i_clk);
      chk("two pulses", 0, ovf[0]);
      pins.pulse(0, 1);
      repeat (6) @(posedge i_clk);
      chk("three pulses", 1, ovf[0]);
      wr(ADDR_CTRL, 8'h00);
      done("count pin");
      // pwm: low cycles over two periods; flag mirrors the wave
      wr(ADDR_AUX, 8'h01);
      wr(ADDR_MODE, 8'h02);
      foreach (pw[i]) begin
         wr(ADDR_HI0, pw[i]);
         wr(ADDR_CTRL, 8'h10);
         repeat (300) @(posedge i_clk);
         chk("pwm enable", 1, pin_oe[0]);
         {lows, bad} = '0;
         repeat (512) begin
            @(posedge i_clk);
            if (pin_out[0] === 1'b0) lows++;
            if (ovf[0] !== pin_out[0]) bad++;
         end
         chkn("pwm low cycles", pw[i] == 8'hff ? 512 : 2 * int'(pw[i]), lows);
         chkn("pwm flag", 0, bad);
         wr(ADDR_CTRL, 8'h00);
      end
      done("pwm");
      final_report();
   end
endmodule
